// *** logic/fault_sup_pkg.sv ***
// Shared constants and carrier types for the gate driver fault supervisor
package fault_sup_pkg;
    // ****************************************
    // Geometry and encodings
    // ****************************************
    localparam int NUM_HB = 8;
    localparam int TIME_W = 8;
    localparam logic [1:0] HB_OFF_LO = 2'h0;
    localparam logic [1:0] HB_OFF_HI = 2'h3;
    localparam logic [1:0] PASS_BRAKE = 2'h2;
    localparam logic [1:0] PASS_BRAKE_PWM = 2'h3;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ = 20;
    localparam int PUMP_CLEAR_HOLD_US = 64;
    localparam int PUMP_CLEAR_HOLD_CYC = PUMP_CLEAR_HOLD_US * CLK_MHZ;
    localparam int HOLD_W = 11;
    localparam int PUMP_CHARGE_LIMIT_US = 200;
    localparam int PUMP_CHARGE_LIMIT_CYC = PUMP_CHARGE_LIMIT_US * CLK_MHZ;
    localparam int CHG_W = 13;

    // Analog comparator levels, asynchronous to the clock until the supervisor synchronises them
    typedef struct packed {
        logic temp_warn;
        logic temp_shutdown;
        logic supply_under;
        logic supply_over;
        logic supply_pass_over;
        logic pump_under;
    } monitor_type;

    // Latched fault flags as seen in the general status register
    typedef struct packed {
        logic supply_error;
        logic thermal_warning;
        logic thermal_shutdown;
        logic supply_undervoltage;
        logic supply_overvoltage;
        logic pump_undervoltage;
        logic global_error;
    } fault_flags_type;

    // Effective switching times of one measured edge pair
    typedef struct packed {
        logic [TIME_W-1:0] turn_on_delay;
        logic [TIME_W-1:0] turn_off_delay;
        logic [TIME_W-1:0] rise_time;
        logic [TIME_W-1:0] fall_time;
    } switch_times_type;
endpackage

// *** logic/switch_timer.sv ***
// Effective switching delay and edge time measurement for one PWM channel
`timescale 1ns/1ps
module switch_timer
    import fault_sup_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    input wire logic generator_detect_enable_i,
    input wire logic pwm_cmd_i,
    input wire logic gate_above_th_i,
    input wire logic gate_full_i,
    input wire logic gate_below_low_i,
    input wire logic [TIME_W-1:0] blanking_time_i,
    input wire logic [TIME_W-1:0] cross_conduction_time_i,
    output logic [4*TIME_W-1:0] times_o,
    output logic generator_mode_o
);
    typedef enum logic [2:0] {T_IDLE, T_ON_DLY, T_RISE, T_HIGH, T_OFF_DLY, T_FALL} tstate_type;
    tstate_type st_q;
    logic cmd_q;
    logic [TIME_W-1:0] cnt_q;
    switch_times_type times_q;
    logic gen_q;

    assign times_o = times_q;
    assign generator_mode_o = gen_q;

    // Edge timing sequencer; counter saturates rather than wraps
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q <= T_IDLE;
            cmd_q <= 1'b0;
            cnt_q <= '0;
            times_q <= '0;
            gen_q <= 1'b0;
        end else if (clk_en_i) begin
            cmd_q <= pwm_cmd_i;
            cnt_q <= (&cnt_q) ? cnt_q : cnt_q + 1'b1;
            case (st_q)
                T_IDLE: begin
                    if (pwm_cmd_i && !cmd_q) begin
                        st_q <= T_ON_DLY;
                        cnt_q <= '0;
                    end
                end
                T_ON_DLY: begin
                    if (gate_above_th_i) begin
                        times_q.turn_on_delay <= cnt_q;
                        st_q <= T_RISE;
                        cnt_q <= '0;
                    end else if (cnt_q >= blanking_time_i && !gen_q) begin
                        times_q.turn_on_delay <= blanking_time_i;
                        st_q <= T_RISE;
                        cnt_q <= '0;
                    end
                end
                T_RISE: begin
                    if (gate_full_i) begin
                        times_q.rise_time <= cnt_q;
                        st_q <= T_HIGH;
                    end
                end
                T_HIGH: begin
                    if (!pwm_cmd_i) begin
                        st_q <= T_OFF_DLY;
                        cnt_q <= '0;
                    end
                end
                T_OFF_DLY: begin
                    if (!gate_full_i) begin
                        times_q.turn_off_delay <= cnt_q;
                        gen_q <= 1'b0;
                        st_q <= T_FALL;
                        cnt_q <= '0;
                    end else if (cnt_q >= cross_conduction_time_i) begin
                        if (!generator_detect_enable_i) begin
                            times_q.turn_off_delay <= cross_conduction_time_i;
                        end else begin
                            gen_q <= 1'b1;
                        end
                        st_q <= T_FALL;
                        cnt_q <= '0;
                    end
                end
                T_FALL: begin
                    if (gate_below_low_i) begin
                        times_q.fall_time <= cnt_q;
                        st_q <= T_IDLE;
                    end
                end
                default: st_q <= T_IDLE;
            endcase
        end
    end
endmodule

// *** logic/gate_driver_fault_supervisor.sv ***
// Fault latching, off-state diagnostic and switching-time supervision of the gate driver
`timescale 1ns/1ps
// What this block does
// - Each switch-node pull-down is on only when its own enable bit is set.
// - Output level of each of eight half-bridges is reported while it is off.
// - Output level bit reads 0 while its half-bridge is in an on mode.
// - Thermal warning latches, outputs stay on, clear works once warning gone.
// - Thermal shutdown latches drivers off, stops pump, sets three flags.
// - Outputs stay off after shutdown until heat gone and status cleared.
// - Thermal or overvoltage shutdown discharges gates with static discharge setting.
// - Supply undervoltage latches MOSFETs off and sets three flags, logic kept.
// - Supply under/overvoltage flags clear only after recovery plus a clear command.
// - Supply overvoltage latches MOSFETs off, stops pump, sets three flags.
// - Pump restarts by itself after overvoltage recovers; MOSFETs wait for clear.
// - Passive mode 10: brake low sides on at overvoltage, pull PWM three low.
// - Passive mode 11: brake only while PWM one high, pull PWM three low.
// - Logic supply reset resets logic and turns drivers off.
// - Pump undervoltage discharges statically for cross-conduction time, then turns off.
// - Pump undervoltage latches pump, supply and global error flags until cleared.
// - Pump undervoltage reported if pump not charged within limit after reset.
// - Turn-on, turn-off delays and rise, fall times are measured and reported.
// - Blanking expiry before turn-on measured reports blanking time as turn-on delay, unless generator mode is flagged.
// - Cross-conduction expiry without generator check reports it as turn-off delay.
// - Pump flag clears only 64 us after supply or thermal recovery.
// - With generator check, unmeasured turn-off delay marks motor as generator.
module gate_driver_fault_supervisor
    import fault_sup_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    input wire logic [$bits(monitor_type)-1:0] monitor_i,
    input wire logic status_clear_i,
    input wire logic bridge_passive_flag_i,
    input wire logic [1:0] passive_mode_select_i,
    input wire logic overvoltage_threshold_select_i,
    input wire logic [2*NUM_HB-1:0] half_bridge_mode_i,
    input wire logic [NUM_HB-1:0] diag_pulldown_enable_i,
    input wire logic [NUM_HB-1:0] half_bridge_switch_node_i,
    input wire logic [TIME_W-1:0] cross_conduction_time_i,
    input wire logic [TIME_W-1:0] blanking_time_i,
    input wire logic generator_detect_enable_i,
    input wire logic pwm_input_one_i,
    input wire logic pwm_cmd_i,
    input wire logic gate_above_th_i,
    input wire logic gate_full_i,
    input wire logic gate_below_low_i,
    output logic [$bits(fault_flags_type)-1:0] general_status_o,
    output logic [NUM_HB-1:0] output_level_status_o,
    output logic [NUM_HB-1:0] diag_pulldown_o,
    output logic drivers_enable_o,
    output logic static_discharge_o,
    output logic pump_enable_o,
    output logic overvoltage_threshold_o,
    output logic [3:0] brake_low_side_drivers_o,
    output logic pwm_input_three_pd_o,
    output logic pwm_input_three_oe_n_o,
    output logic [4*TIME_W-1:0] effective_times_o,
    output logic generator_mode_o
);
    // ****************************************
    // Input synchronisers
    // ****************************************
    monitor_type mon_meta_q, mon_q;
    logic [NUM_HB-1:0] sw_meta_q, sw_q;
    logic pwm_input_one_meta_q, pwm_input_one_q;

    // Analog comparators and pins are asynchronous to the logic clock
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mon_meta_q <= '{pump_under: 1'b1, default: 1'b0}; // Pump counts as uncharged until seen
            mon_q <= '{pump_under: 1'b1, default: 1'b0};
            sw_meta_q <= '0;
            sw_q <= '0;
            pwm_input_one_meta_q <= 1'b0;
            pwm_input_one_q <= 1'b0;
        end else if (clk_en_i) begin
            mon_meta_q <= monitor_i;
            mon_q <= mon_meta_q;
            sw_meta_q <= half_bridge_switch_node_i;
            sw_q <= sw_meta_q;
            pwm_input_one_meta_q <= pwm_input_one_i;
            pwm_input_one_q <= pwm_input_one_meta_q;
        end
    end

    // ****************************************
    // Off-state diagnostic
    // ****************************************
    function automatic logic hb_is_off(input logic [1:0] m);
        return (m == HB_OFF_LO) || (m == HB_OFF_HI);
    endfunction

    logic [NUM_HB-1:0] level_q;
    // Controller alone decides when diagnostics run; device just gates the current
    genvar g;
    generate
        for (g = 0; g < NUM_HB; g++) begin : g_hb
            assign diag_pulldown_o[g] = diag_pulldown_enable_i[g];
            always_ff @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    level_q[g] <= 1'b0;
                end else if (clk_en_i) begin
                    level_q[g] <= hb_is_off(half_bridge_mode_i[2*g +: 2]) ? sw_q[g] : 1'b0;
                end
            end
        end
    endgenerate
    assign output_level_status_o = level_q;
    // Threshold select passes through; the 2 V setting is the controller's job
    assign overvoltage_threshold_o = overvoltage_threshold_select_i;

    // ****************************************
    // Fault flags
    // ****************************************
    fault_flags_type flags_q;
    logic [HOLD_W-1:0] hold_q;
    logic [CHG_W-1:0] chg_q;
    logic charged_q;
    logic supply_fault;
    logic pump_clear_ok;

    assign supply_fault = mon_q.temp_shutdown || mon_q.supply_under || mon_q.supply_over;
    assign pump_clear_ok = (hold_q == HOLD_W'(PUMP_CLEAR_HOLD_CYC));

    // Recovery hold: restarts while any pump-stopping fault is present
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hold_q <= HOLD_W'(PUMP_CLEAR_HOLD_CYC);
        end else if (clk_en_i) begin
            if (supply_fault) begin
                hold_q <= '0;
            end else if (!pump_clear_ok) begin
                hold_q <= hold_q + 1'b1;
            end
        end
    end

    // Pump charge timeout after reset release
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            chg_q <= '0;
            charged_q <= 1'b0;
        end else if (clk_en_i && !charged_q) begin
            if (!mon_q.pump_under) begin
                charged_q <= 1'b1;
            end else if (chg_q != CHG_W'(PUMP_CHARGE_LIMIT_CYC)) begin
                chg_q <= chg_q + 1'b1;
            end
        end
    end

    logic pump_event;
    // Late charge raises the flag too
    assign pump_event = (mon_q.pump_under && charged_q) || (!charged_q && chg_q == CHG_W'(PUMP_CHARGE_LIMIT_CYC));

    // Set wins over clear; clear acts only on flags whose cause is gone
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flags_q <= '0;
        end else if (clk_en_i) begin
            if (status_clear_i) begin
                if (!mon_q.temp_warn) flags_q.thermal_warning <= 1'b0;
                if (!mon_q.temp_shutdown) flags_q.thermal_shutdown <= 1'b0;
                if (!mon_q.supply_under) flags_q.supply_undervoltage <= 1'b0;
                if (!mon_q.supply_over) flags_q.supply_overvoltage <= 1'b0;
                if (!mon_q.pump_under && charged_q && pump_clear_ok) begin
                    flags_q.pump_undervoltage <= 1'b0;
                    flags_q.supply_error <= 1'b0;
                    flags_q.global_error <= 1'b0;
                end
            end
            if (mon_q.temp_warn) flags_q.thermal_warning <= 1'b1;
            if (mon_q.temp_shutdown) flags_q.thermal_shutdown <= 1'b1;
            if (mon_q.supply_under) flags_q.supply_undervoltage <= 1'b1;
            if (mon_q.supply_over) flags_q.supply_overvoltage <= 1'b1;
            if (supply_fault || pump_event) begin
                flags_q.pump_undervoltage <= 1'b1;
                flags_q.supply_error <= 1'b1;
            end
            if (pump_event) flags_q.global_error <= 1'b1;
        end
    end
    assign general_status_o = flags_q;

    // ****************************************
    // Driver and pump control
    // ****************************************
    typedef enum logic [1:0] {D_RUN, D_DISCHARGE, D_OFF} dstate_type;
    dstate_type dst_q;
    logic [TIME_W-1:0] dis_cnt_q;
    logic lock_off;

    // Any latched shutdown flag keeps gates off; warning alone does not
    assign lock_off = flags_q.thermal_shutdown || flags_q.supply_undervoltage ||
                      flags_q.supply_overvoltage || flags_q.pump_undervoltage;

    // Pump discharge waits the cross-conduction time before full turn-off
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dst_q <= D_RUN; // Reset itself holds drivers off
            dis_cnt_q <= '0;
        end else if (clk_en_i) begin
            case (dst_q)
                D_RUN: begin
                    if (lock_off) begin
                        dst_q <= D_DISCHARGE;
                        dis_cnt_q <= '0;
                    end
                end
                D_DISCHARGE: begin
                    dis_cnt_q <= dis_cnt_q + 1'b1;
                    if (dis_cnt_q >= cross_conduction_time_i) dst_q <= D_OFF;
                end
                D_OFF: begin
                    if (!lock_off) dst_q <= D_RUN;
                end
                default: dst_q <= D_OFF;
            endcase
        end
    end

    logic drv_en_q, stat_dis_q, pump_en_q;
    // Registered drive outputs; thermal and overvoltage use static discharge
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            drv_en_q <= 1'b0;
            stat_dis_q <= 1'b0;
            pump_en_q <= 1'b0;
        end else if (clk_en_i) begin
            drv_en_q <= (dst_q == D_RUN) && !lock_off && !bridge_passive_flag_i;
            stat_dis_q <= (dst_q == D_DISCHARGE) || (lock_off && (mon_q.temp_shutdown || mon_q.supply_over));
            pump_en_q <= !(mon_q.temp_shutdown || mon_q.supply_over);
        end
    end
    assign drivers_enable_o = drv_en_q;
    assign static_discharge_o = stat_dis_q;
    assign pump_enable_o = pump_en_q;

    // ****************************************
    // Passive-mode overvoltage brake
    // ****************************************
    logic brake_q, pd_q;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            brake_q <= 1'b0;
            pd_q <= 1'b0;
        end else if (clk_en_i) begin
            pd_q <= bridge_passive_flag_i &&
                    (passive_mode_select_i == PASS_BRAKE || passive_mode_select_i == PASS_BRAKE_PWM);
            brake_q <= bridge_passive_flag_i && mon_q.supply_pass_over &&
                       ((passive_mode_select_i == PASS_BRAKE) ||
                        (passive_mode_select_i == PASS_BRAKE_PWM && pwm_input_one_q));
        end
    end
    assign brake_low_side_drivers_o = {4{brake_q}};
    assign pwm_input_three_pd_o = 1'b0;
    assign pwm_input_three_oe_n_o = !pd_q;

    // ****************************************
    // Switching-time measurement
    // ****************************************
    switch_timer u_timer (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .clk_en_i(clk_en_i),
        .generator_detect_enable_i(generator_detect_enable_i),
        .pwm_cmd_i(pwm_cmd_i),
        .gate_above_th_i(gate_above_th_i),
        .gate_full_i(gate_full_i),
        .gate_below_low_i(gate_below_low_i),
        .blanking_time_i(blanking_time_i),
        .cross_conduction_time_i(cross_conduction_time_i),
        .times_o(effective_times_o),
        .generator_mode_o(generator_mode_o)
    );

    // ****************************************
    // Assertions
    // ****************************************
    property p_warn_keeps_outputs;
        @(posedge clk_i) disable iff (!resetn_i)
        $rose(flags_q.thermal_warning) && !lock_off && dst_q == D_RUN && !bridge_passive_flag_i && clk_en_i
        |=> drv_en_q;
    endproperty
    a_warn_keeps_outputs: assert property (p_warn_keeps_outputs) else $error("warning turned outputs off");

    property p_tsd_off;
        @(posedge clk_i) disable iff (!resetn_i)
        clk_en_i && mon_q.temp_shutdown ##1 clk_en_i |-> !pump_en_q ##1 !drv_en_q;
    endproperty
    a_tsd_off: assert property (p_tsd_off) else $error("shutdown left drivers or pump on");

    property p_level_zero_on;
        @(posedge clk_i) disable iff (!resetn_i)
        clk_en_i && !hb_is_off(half_bridge_mode_i[1:0]) |=> !output_level_status_o[0];
    endproperty
    a_level_zero_on: assert property (p_level_zero_on) else $error("level bit set in on mode");

    property p_clear_keeps_present;
        @(posedge clk_i) disable iff (!resetn_i)
        clk_en_i && mon_q.supply_under |=> flags_q.supply_undervoltage;
    endproperty
    a_clear_keeps_present: assert property (p_clear_keeps_present) else $error("present fault flag cleared");

    property p_pump_hold;
        @(posedge clk_i) disable iff (!resetn_i)
        flags_q.pump_undervoltage && !pump_clear_ok |=> flags_q.pump_undervoltage;
    endproperty
    a_pump_hold: assert property (p_pump_hold) else $error("pump flag cleared too early");

    property p_brake_mode;
        @(posedge clk_i) disable iff (!resetn_i)
        brake_q |-> $past(bridge_passive_flag_i) && $past(passive_mode_select_i[1]);
    endproperty
    a_brake_mode: assert property (p_brake_mode) else $error("brake outside passive mode");

    property p_brake_pwm_input_one;
        @(posedge clk_i) disable iff (!resetn_i)
        brake_q && $past(passive_mode_select_i) == PASS_BRAKE_PWM |-> $past(pwm_input_one_q);
    endproperty
    a_brake_pwm_input_one: assert property (p_brake_pwm_input_one) else $error("brake without pwm one");

    property p_drivers_need_clear;
        @(posedge clk_i) disable iff (!resetn_i)
        clk_en_i && lock_off |=> !drv_en_q;
    endproperty
    a_drivers_need_clear: assert property (p_drivers_need_clear) else $error("drivers on while latched");

    c_tsd: cover property (@(posedge clk_i) disable iff (!resetn_i) $rose(flags_q.thermal_shutdown));
    c_discharge: cover property (@(posedge clk_i) disable iff (!resetn_i) dst_q == D_DISCHARGE ##1 dst_q == D_OFF);
    c_brake: cover property (@(posedge clk_i) disable iff (!resetn_i) $rose(brake_q));
    c_gen: cover property (@(posedge clk_i) disable iff (!resetn_i) $rose(generator_mode_o));
endmodule

// *** tb/ctrl_host_model.sv ***
// Behavioural controller on the far side: status clears and diagnostic pull-down requests
`timescale 1ns/1ps
module ctrl_host_model
    import fault_sup_pkg::*;
(
    input wire logic clk_i,
    input wire logic bridge_passive_flag_i,
    input wire logic [2*NUM_HB-1:0] half_bridge_mode_i,
    output logic status_clear_o,
    output logic [NUM_HB-1:0] diag_pulldown_enable_o
);
    logic [NUM_HB-1:0] want = '0;
    initial status_clear_o = 1'b0;
    // Pull-downs only asked for on an active bridge and an off half-bridge
    always_comb begin
        for (int i = 0; i < NUM_HB; i++) begin
            diag_pulldown_enable_o[i] = want[i] && !bridge_passive_flag_i &&
                (half_bridge_mode_i[2*i+:2] == HB_OFF_LO || half_bridge_mode_i[2*i+:2] == HB_OFF_HI);
        end
    end
    // One-cycle clear of the general status, launched just after an edge
    task automatic clear();
        @(posedge clk_i);
        #5 status_clear_o = 1'b1;
        @(posedge clk_i);
        #5 status_clear_o = 1'b0;
    endtask
    task automatic diag(input logic [NUM_HB-1:0] m);
        want = m;
    endtask
endmodule

// *** tb/gate_driver_fault_supervisor_bench.sv ***
// Self-checking bench for the gate driver fault supervisor
`timescale 1ns/1ps
module gate_driver_fault_supervisor_bench;
    import fault_sup_pkg::*;
    localparam logic [7:0] BLK = 8'h05;
    localparam logic [7:0] CCT = 8'h06;
    logic clk_i = 0, resetn_i = 0, cen = 1, pas = 0, ovs = 0, pw1 = 0, pwm = 0, gat = 0, gfull = 0, glow = 0, gen = 0;
    logic clr, drv, sdis, pen, ovo, oe_n, pd3, genm;
    monitor_type mon = '0;
    logic [1:0] pms = 2'h0;
    logic [15:0] mode = 16'h0000;
    logic [7:0] sw = 8'h00, lvl, pd, den;
    logic [6:0] st;
    logic [3:0] brk;
    logic [31:0] tms;
    int num_errors = 0, tests_run = 0;
    always #25 clk_i = ~clk_i;
    ctrl_host_model host (.clk_i(clk_i), .bridge_passive_flag_i(pas), .half_bridge_mode_i(mode),
        .status_clear_o(clr), .diag_pulldown_enable_o(den));
    gate_driver_fault_supervisor DUT (.clk_i(clk_i), .resetn_i(resetn_i), .clk_en_i(cen), .monitor_i(mon),
        .status_clear_i(clr), .bridge_passive_flag_i(pas), .passive_mode_select_i(pms),
        .overvoltage_threshold_select_i(ovs), .half_bridge_mode_i(mode), .diag_pulldown_enable_i(den),
        .half_bridge_switch_node_i(sw), .cross_conduction_time_i(CCT), .blanking_time_i(BLK),
        .generator_detect_enable_i(gen), .pwm_input_one_i(pw1), .pwm_cmd_i(pwm), .gate_above_th_i(gat),
        .gate_full_i(gfull), .gate_below_low_i(glow), .general_status_o(st), .output_level_status_o(lvl),
        .diag_pulldown_o(pd), .drivers_enable_o(drv), .static_discharge_o(sdis), .pump_enable_o(pen),
        .overvoltage_threshold_o(ovo), .brake_low_side_drivers_o(brk), .pwm_input_three_pd_o(pd3),
        .pwm_input_three_oe_n_o(oe_n), .effective_times_o(tms), .generator_mode_o(genm));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    // Inputs always move 5 ns after the edge, well clear of sampling
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #5;
    endtask
    task automatic results();
        $display("Checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        step(12);
        chk(drv, 0);
        resetn_i = 1;
        step(10);
        chk(st, 0);
        chk(drv, 1);
        mon.temp_warn = 1;
        step(6);
        chk(st, 7'h20);
        chk(drv, 1);
        host.clear();
        step(2);
        chk(st, 7'h20);
        mon.temp_warn = 0;
        step(4);
        host.clear();
        step(2);
        chk(st, 0);
        $display("Test thermal warning done");
        mon.temp_shutdown = 1;
        step(4);
        chk(st, 7'h52);
        chk(pen, 0);
        step(2);
        chk(drv, 0);
        chk(sdis, 1);
        mon.temp_shutdown = 0;
        step(4);
        host.clear();
        step(2);
        chk(st, 7'h42);
        chk(drv, 0);
        step(1300);
        host.clear();
        step(4);
        chk(st, 0);
        chk(drv, 1);
        $display("Test thermal shutdown done");
        mon.supply_under = 1;
        step(6);
        chk(st, 7'h4A);
        chk(drv, 0);
        host.clear();
        step(2);
        chk(st, 7'h4A);
        mon.supply_under = 0;
        step(1300);
        host.clear();
        step(4);
        chk(st, 0);
        ovs = 1;
        mon.supply_over = 1;
        step(6);
        chk(ovo, 1);
        chk(st, 7'h46);
        chk(pen, 0);
        mon.supply_over = 0;
        step(6);
        chk(pen, 1);
        chk(drv, 0);
        step(1300);
        host.clear();
        step(4);
        chk(st, 0);
        chk(drv, 1);
        $display("Test supply faults done");
        mon.pump_under = 1;
        step(6);
        chk(st, 7'h43);
        chk(sdis, 1);
        chk(drv, 0);
        step(14);
        chk(sdis, 0);
        mon.pump_under = 0;
        step(4);
        host.clear();
        step(2);
        chk(st, 0);
        // Mid-run reset with an uncharged pump: flag only after the charge limit
        resetn_i = 0;
        mon.pump_under = 1;
        step(2);
        resetn_i = 1;
        step(3900);
        chk(st, 0);
        step(300);
        chk(st, 7'h43);
        mon.pump_under = 0;
        step(4);
        host.clear();
        step(2);
        chk(st, 0);
        $display("Test pump undervoltage done");
        sw = 8'hA5;
        host.diag(8'h3C);
        step(5);
        chk(lvl, 8'hA5);
        chk(pd, 8'h3C);
        mode = 16'h9006;
        step(5);
        chk(lvl, 8'h24);
        chk(pd, den);
        $display("Test off-state diagnostic done");
        pas = 1;
        pms = PASS_BRAKE;
        mon.supply_pass_over = 1;
        step(5);
        chk(brk, 4'hF);
        chk({oe_n, pd3}, 0);
        pms = PASS_BRAKE_PWM;
        step(5);
        chk(brk, 4'h0);
        pw1 = 1;
        step(5);
        chk(brk, 4'hF);
        pas = 0;
        pms = 2'h0;
        mon.supply_pass_over = 0;
        step(5);
        chk({brk, oe_n}, 5'h01);
        $display("Test passive brake done");
        pwm = 1;
        step(3);
        gat = 1;
        step(2);
        gfull = 1;
        step(3);
        chk(tms[31:24] < BLK, 1);
        pwm = 0;
        step(3);
        {gfull, gat} = 2'h0;
        step(3);
        chk(tms[23:16] < CCT, 1);
        glow = 1;
        step(2);
        chk(tms[15:8] != 0 && tms[7:0] != 0, 1);
        pwm = 1;
        step(BLK + 10);
        chk(tms[31:24], BLK);
        {gfull, gat} = 2'h3;
        step(3);
        pwm = 0;
        step(CCT + 10);
        chk(tms[23:16], CCT);
        chk(genm, 0);
        gen = 1;
        pwm = 1;
        step(5);
        pwm = 0;
        step(CCT + 10);
        chk(genm, 1);
        $display("Test switching times done");
        // Enable low freezes synchronisers and flags alike
        cen = 0;
        mon.temp_warn = 1;
        step(6);
        chk(st, 0);
        cen = 1;
        step(4);
        chk(st, 7'h20);
        $display("Test clock enable done");
        results();
    end
    // Watchdog sized well beyond the roughly 8350 cycles the sequence needs
    initial begin
        #(15000 * 50);
        num_errors++;
        results();
    end
endmodule
